/* File: verilog/scan_chain_consts.svh */
`ifndef SCAN_CHAIN_CONSTS_SVH
`define SCAN_CHAIN_CONSTS_SVH
`define CHAIN_LEN 67
`define RSVD_BIT_A 56
`define RSVD_BIT_B 57
`define SCAN_SERIAL_OUT_RESET 1'b0
`endif

/* File: verilog/scan_chain_pkg.sv */
package scan_chain_pkg;
   typedef struct packed {
      logic enable;
      logic select;
      logic sclk;
      logic oe_n;
   } scan_ctrl_s;
   typedef struct packed {
      logic reset_pin;
      logic mirror;
      logic strobe0;
      logic cs_n;
   } normal_pins_s;
endpackage

/* File: verilog/dram_boundary_scan_chain.sv */
`timescale 1ns/1ps
`include "scan_chain_consts.svh"
module dram_boundary_scan_chain
   import scan_chain_pkg::*;
#(
   parameter int CHAIN_LEN = `CHAIN_LEN
) (
   input wire logic mclk,
   input wire logic rst,
   input wire scan_ctrl_s scan_in,
   input wire normal_pins_s pins_in,
   input wire logic [CHAIN_LEN-1:0] pad_levels,
   output logic scan_serial_out,
   output logic scan_serial_oe,
   output logic scan_mode,
   output logic command_block,
   output logic mirror_active,
   output logic cmd_addr_term_nominal,
   output logic data_term_enable,
   output normal_pins_s pins_out
);
   // A chain too short to hold the reserved cells is refused when the block is built.
   generate
      if (CHAIN_LEN < `RSVD_BIT_B) begin : g_len_check
         $error("CHAIN_LEN too small for the reserved cells");
      end
   endgenerate

   // Every pin input crosses into mclk through two flip-flops before use.
   scan_ctrl_s ctrl_m_q;
   scan_ctrl_s ctrl_s_q;
   normal_pins_s pins_m_q;
   normal_pins_s pins_s_q;
   logic [CHAIN_LEN-1:0] pads_m_q;
   logic [CHAIN_LEN-1:0] pads_s_q;
   logic sclk_prev_q;
   logic [CHAIN_LEN-1:0] chain_q;
   logic oe_n_q;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_m_q <= '0;
         ctrl_s_q <= '0;
      end else begin
         ctrl_m_q <= scan_in;
         ctrl_s_q <= ctrl_m_q;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pins_m_q <= '0;
         pins_s_q <= '0;
      end else begin
         pins_m_q <= pins_in;
         pins_s_q <= pins_m_q;
      end
   end

   // Pads must stand still around a scan clock rise, so bitwise synchronisers are enough.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pads_m_q <= '0;
         pads_s_q <= '0;
      end else begin
         pads_m_q <= pad_levels;
         pads_s_q <= pads_m_q;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= ctrl_s_q.sclk;
      end
   end

   // Scan clock edges count only in scan mode, so normal traffic on the pin is ignored.
   wire scan_on = ctrl_s_q.enable;
   wire sclk_rise = scan_on && ctrl_s_q.sclk && !sclk_prev_q;

   // Reserved cells are masked at capture so they always capture a zero; a shift can still move a one into them.
   function automatic logic [CHAIN_LEN-1:0] mask_reserved(input logic [CHAIN_LEN-1:0] v);
      logic [CHAIN_LEN-1:0] r;
      r = v;
      r[`RSVD_BIT_A-1] = 1'b0;
      r[`RSVD_BIT_B-1] = 1'b0;
      return r;
   endfunction

   // Index 0 is exit bit 1; a shift moves every cell one place toward index 0.
   wire [CHAIN_LEN-1:0] shift_d;
   generate
      for (genvar i = 0; i < CHAIN_LEN - 1; i++) begin : g_cell
         assign shift_d[i] = chain_q[i+1];
      end
   endgenerate
   // The last cell's spare input is grounded, so an overrun shifts in zeros.
   assign shift_d[CHAIN_LEN-1] = 1'b0;
   wire [CHAIN_LEN-1:0] capture_d = mask_reserved(pads_s_q);
   wire [CHAIN_LEN-1:0] chain_d = ctrl_s_q.select ? shift_d : capture_d;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         chain_q <= '0;
      end else if (sclk_rise) begin
         chain_q <= chain_d;
      end
   end

   // Leaving scan mode disables the output, so a later entry never starts out driving.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         oe_n_q <= 1'b1;
      end else if (sclk_rise) begin
         oe_n_q <= ctrl_s_q.oe_n;
      end else if (!scan_on) begin
         oe_n_q <= 1'b1;
      end
   end

   wire out_en = scan_on && !oe_n_q;
   wire scan_serial_out_d = out_en ? chain_q[0] : `SCAN_SERIAL_OUT_RESET;
   wire mirror_d = !scan_on && pins_s_q.mirror;
   // In scan mode the borrowed pins are withheld from the memory core.
   wire normal_pins_s pins_d = scan_on ? '0 : pins_s_q;

   // Each output has a register of its own so every pin comes straight from a flip-flop.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scan_serial_out <= `SCAN_SERIAL_OUT_RESET;
      end else begin
         scan_serial_out <= scan_serial_out_d;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scan_serial_oe <= 1'b0;
      end else begin
         scan_serial_oe <= out_en;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scan_mode <= 1'b0;
      end else begin
         scan_mode <= scan_on;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         command_block <= 1'b0;
      end else begin
         command_block <= scan_on;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mirror_active <= 1'b0;
      end else begin
         mirror_active <= mirror_d;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmd_addr_term_nominal <= 1'b0;
      end else begin
         cmd_addr_term_nominal <= scan_on;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_term_enable <= 1'b1;
      end else begin
         data_term_enable <= !scan_on;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pins_out <= '0;
      end else begin
         pins_out <= pins_d;
      end
   end
endmodule // dram_boundary_scan_chain

/* File: verif/scan_tester.sv */
`timescale 1ns/1ps
module scan_tester
   import scan_chain_pkg::*;
(
   input wire logic mclk,
   output scan_ctrl_s ctl
);
   initial ctl = '0;
   // Scan clock stands low between pulses and never free-runs.
   task automatic pulse(input logic sel, input logic oe_n);
      @(posedge mclk);
      ctl.select <= sel;
      ctl.oe_n <= oe_n;
      repeat (3) @(posedge mclk);
      ctl.sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      ctl.sclk <= 1'b0;
   endtask
   task automatic set_en(input logic e);
      @(posedge mclk);
      ctl.enable <= e;
      repeat (4) @(posedge mclk);
   endtask
endmodule // scan_tester

/* File: verif/dram_boundary_scan_chain_assertions.sv */
`timescale 1ns/1ps
module dram_boundary_scan_chain_assertions
   import scan_chain_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire scan_ctrl_s scan_in,
   input wire logic scan_serial_out,
   input wire logic scan_serial_oe,
   input wire logic scan_mode,
   input wire logic command_block,
   input wire logic mirror_active,
   input wire logic cmd_addr_term_nominal,
   input wire logic data_term_enable
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_quiet;
      (scan_in.enable && !scan_in.sclk)[*4];
   endsequence
   a_scan_entry: assert property (scan_in.enable[*5] |-> scan_mode) else $error("no entry");
   a_scan_exit: assert property (!scan_in.enable[*5] |-> !scan_mode && !scan_serial_oe) else $error("no exit");
   a_cmd_blocked: assert property (scan_in.enable[*4] |-> command_block && scan_mode) else $error("cmd open");
   a_term_set: assert property (cmd_addr_term_nominal == scan_mode && data_term_enable == !scan_mode)
      else $error("term");
   a_mirror_off: assert property (scan_mode |-> !mirror_active) else $error("mirror");
   a_out_gated: assert property (!scan_serial_oe |-> !scan_serial_out) else $error("out driven");
   a_out_hold: assert property (s_quiet |-> $stable(scan_serial_out)) else $error("out moved");
   a_oe_hold: assert property (s_quiet |-> $stable(scan_serial_oe)) else $error("oe moved");
   a_out_timing: assert property (!$stable(scan_serial_out) |->
      ($past(scan_in.sclk, 4) && !$past(scan_in.sclk, 5)) || !$past(scan_in.enable, 3))
      else $error("out moved off edge");
endmodule // dram_boundary_scan_chain_assertions
bind dram_boundary_scan_chain dram_boundary_scan_chain_assertions chk_i(.mclk(mclk), .rst(rst), .scan_in(scan_in),
   .scan_serial_out(scan_serial_out), .scan_serial_oe(scan_serial_oe), .scan_mode(scan_mode),
   .command_block(command_block), .mirror_active(mirror_active),
   .cmd_addr_term_nominal(cmd_addr_term_nominal), .data_term_enable(data_term_enable));

/* File: verif/dram_boundary_scan_chain_tb.sv */
`timescale 1ns/1ps
module dram_boundary_scan_chain_tb;
   import scan_chain_pkg::*;
   logic mclk = 0, rst = 1, so, soe, sm, cb, ma, can, dte;
   scan_ctrl_s ctl;
   normal_pins_s pins_in = '0, pins_out;
   logic [66:0] pads = '0;
   int err_total = 0, n_checks = 0, cyc = 0;
   scan_tester tst(.mclk(mclk), .ctl(ctl));
   dram_boundary_scan_chain uut(.mclk(mclk), .rst(rst), .scan_in(ctl), .pins_in(pins_in), .pad_levels(pads),
      .scan_serial_out(so), .scan_serial_oe(soe), .scan_mode(sm), .command_block(cb), .mirror_active(ma),
      .cmd_addr_term_nominal(can), .data_term_enable(dte), .pins_out(pins_out));
   initial forever #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         complete_run();
      end
   end
   function automatic logic exp_bit(int i);
      return (i == 55 || i == 56 || i > 66) ? 1'b0 : pads[i];
   endfunction
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(98735));
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      pins_in <= normal_pins_s'($urandom);
      // Reserved cells are fed ones so a leak into the chain shows up.
      pads <= 67'({$urandom, $urandom, $urandom}) | 67'h180_0000_0000_0000;
      repeat (6) @(negedge mclk);
      chk({pins_out}, {pins_in});
      chk({can, dte}, 2'b01);
      chk(ma, pins_in.mirror);
      $display("normal mode test done");
      tst.set_en(1'b1);
      tst.pulse(1'b0, 1'b0);
      for (int i = 0; i < 70; i++) begin
         @(negedge mclk);
         chk_bit(so, exp_bit(i));
         tst.pulse(1'b1, 1'b0);
      end
      chk({cb, ma, can, soe}, 4'b1011);
      chk({pins_out}, 4'h0);
      chk({sm, dte}, 2'b10);
      $display("scan shift test done");
      tst.pulse(1'b0, 1'b1);
      repeat (2) @(negedge mclk);
      chk({soe, so}, 2'b00);
      tst.set_en(1'b0);
      repeat (6) @(negedge mclk);
      chk({sm, cb, dte}, 3'b001);
      $display("exit test done");
      complete_run();
   end
endmodule // dram_boundary_scan_chain_tb
